// File: shared/arsf_regs.svh
`ifndef ARSF_REGS_SVH
`define ARSF_REGS_SVH

// Register offsets
`define ARSF_ADDR_W            8
`define ARSF_OFS_STATUS        8'h00
`define ARSF_OFS_CTRL          8'h04
`define ARSF_OFS_RXBUF         8'h08
`define ARSF_OFS_TXBUF         8'h0c

// Status flag masks
`define ARSF_RX_ERROR_SUMMARY_MASK 32'h01000000
`define ARSF_RX_OVERREAD_MASK      32'h00800000
`define ARSF_RX_FRAME_START_MASK   32'h00400000
`define ARSF_RX_DATA_READY_MASK    32'h00200000
`define ARSF_RX_FINAL_SLOT_MASK    32'h00100000
`define ARSF_RX_CLOCK_FAIL_MASK    32'h00040000
`define ARSF_RX_UNEXP_SYNC_MASK    32'h00020000
`define ARSF_TX_UNDERRUN_MASK      32'h00000001

// Control fields
`define ARSF_SLOT_W            5
`define ARSF_SER_W             4
`define ARSF_CTRL_LAST_LSB     0
`define ARSF_CTRL_SER_LSB      8
`define ARSF_CTRL_MON_BIT      16
`define ARSF_CTRL_LAST_RESET   5'h01
`define ARSF_CTRL_SER_RESET    4'h1
`define ARSF_CTRL_MON_RESET    1'h0

// Bit clock monitor timing
`define ARSF_CLK_NS            50
`define ARSF_BCLK_MIN_NS       100
`define ARSF_BCLK_MAX_NS       2000
`define ARSF_BCLK_MIN_CYC      ((`ARSF_BCLK_MIN_NS + `ARSF_CLK_NS - 1) / `ARSF_CLK_NS)
`define ARSF_BCLK_MAX_CYC      (`ARSF_BCLK_MAX_NS / `ARSF_CLK_NS)
`define ARSF_MON_CNT_W         16

`endif

// File: shared/arsf_pkg.sv
`include "arsf_regs.svh"

package arsf_pkg;

   typedef struct packed {
      logic [`ARSF_ADDR_W-1:0] addr;
      logic [31:0]             wdata;
      logic                    wr;
      logic                    rd;
   } arsf_bus_s;

   typedef struct packed {
      logic        frame_sync;
      logic        word_valid;
      logic [31:0] word;
      logic        tx_load;
   } arsf_link_s;

   typedef struct packed {
      logic rx_error_summary;
      logic rx_overread_error;
      logic rx_frame_start;
      logic rx_data_ready;
      logic rx_final_slot;
      logic rx_clock_failure;
      logic rx_unexpected_sync;
      logic tx_underrun;
   } arsf_flags_s;

   typedef struct packed {
      arsf_flags_s             flags;
      logic [`ARSF_SLOT_W-1:0] last_slot;
      logic [`ARSF_SER_W-1:0]  ser_cnt;
      logic                    mon_en;
      logic [`ARSF_SLOT_W-1:0] slot_idx;
      logic                    synced;
      logic                    frame_done;
      logic [`ARSF_SER_W:0]    read_cnt;
      logic [31:0]             rx_buf;
      logic [31:0]             tx_buf;
      logic                    tx_full;
      logic [31:0]             rdata;
      logic                    dma_req;
   } arsf_state_s;

   typedef struct packed {
      logic                       prev;
      logic                       seen;
      logic [`ARSF_MON_CNT_W-1:0] cnt;
      logic                       fail;
   } arsf_mon_state_s;

endpackage : arsf_pkg

// File: rtl/arsf_clk_monitor.sv
`timescale 1ns/100ps
`include "arsf_regs.svh"

module arsf_clk_monitor #(
   parameter int MIN_CYC = `ARSF_BCLK_MIN_CYC,
   parameter int MAX_CYC = `ARSF_BCLK_MAX_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic bit_clk,
   output logic      fail
);
   import arsf_pkg::*;

   localparam logic [`ARSF_MON_CNT_W-1:0] MIN_C = `ARSF_MON_CNT_W'(MIN_CYC);
   localparam logic [`ARSF_MON_CNT_W-1:0] MAX_C = `ARSF_MON_CNT_W'(MAX_CYC);

   arsf_mon_state_s st;
   arsf_mon_state_s next_st;
   logic            rise;

   assign rise = bit_clk && !st.prev;
   assign fail = st.fail;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st      = st;
      next_st.prev = bit_clk;
      next_st.fail = 1'b0;
      if (!enable) begin
         next_st.seen = 1'b0;
         next_st.cnt  = '0;
      end else if (rise) begin
         // Period is cnt+1 cycles; too short means out of range
         if (st.seen && (st.cnt + 1'b1) < MIN_C) begin
            next_st.fail = 1'b1;
         end
         next_st.seen = 1'b1;
         next_st.cnt  = '0;
      end else if (st.seen && st.cnt == MAX_C) begin
         // Re-arm only on the next edge so a dead clock reports once
         next_st.fail = 1'b1;
         next_st.seen = 1'b0;
      end else if (st.cnt != MAX_C) begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_clk_loss_flag: assert property (@(posedge clk) disable iff (!rst_n)
      enable && st.seen && !rise && st.cnt == MAX_C |=> fail)
      else $error("bit clock loss not reported");

endmodule : arsf_clk_monitor

// File: rtl/arsf_status.sv
// Notes on behaviour
// - Error summary bit is OR of unexpected sync, clock failure, overread flags
// - Overread flag sets on more data-port reads in a slot than receivers
// - Frame start flag sets on each new receive frame sync
// - Data ready flag sets when a received word lands in the buffer
// - Every data ready set also raises a DMA request pulse, unconditionally
// - Final slot flag sets with data ready when slot is last in frame
// - Unexpected sync flag sets when frame sync arrives before frame ends
// - Underrun flag sets when serializer loads an unrefilled transmit buffer
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "arsf_regs.svh"

module arsf_status #(
   parameter int MIN_CYC = `ARSF_BCLK_MIN_CYC,
   parameter int MAX_CYC = `ARSF_BCLK_MAX_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire arsf_pkg::arsf_bus_s  bus,
   output logic [31:0]               rdata,
   input  wire arsf_pkg::arsf_link_s link,
   input  wire logic                 rx_bit_clk,
   output logic [31:0]               tx_word,
   output logic                      rx_dma_req,
   output arsf_pkg::arsf_flags_s     flags
);
   import arsf_pkg::*;

   arsf_state_s st;
   arsf_state_s next_st;
   logic        clk_fail;
   logic        wr_status;
   logic        wr_ctrl;
   logic        wr_tx;
   logic        rd_rx;
   logic [31:0] clr;

   assign wr_status = bus.wr && bus.addr == `ARSF_OFS_STATUS;
   assign wr_ctrl   = bus.wr && bus.addr == `ARSF_OFS_CTRL;
   assign wr_tx     = bus.wr && bus.addr == `ARSF_OFS_TXBUF;
   assign rd_rx     = bus.rd && bus.addr == `ARSF_OFS_RXBUF;
   assign clr       = wr_status ? bus.wdata : 32'h0;

   assign rdata      = st.rdata;
   assign tx_word    = st.tx_buf;
   assign rx_dma_req = st.dma_req;
   assign flags      = st.flags;

   ////////////////////////////////////////////////////////////////////////////
   arsf_clk_monitor #(
      .MIN_CYC (MIN_CYC),
      .MAX_CYC (MAX_CYC)
   ) u_mon (
      .clk     (clk),
      .rst_n   (rst_n),
      .enable  (st.mon_en),
      .bit_clk (rx_bit_clk),
      .fail    (clk_fail)
   );

   ////////////////////////////////////////////////////////////////////////////
   function automatic arsf_flags_s clear_flags(arsf_flags_s f, logic [31:0] c);
      arsf_flags_s r;
      r = f;
      if ((c & `ARSF_RX_OVERREAD_MASK) != 32'h0) r.rx_overread_error = 1'b0;
      if ((c & `ARSF_RX_FRAME_START_MASK) != 32'h0) r.rx_frame_start = 1'b0;
      if ((c & `ARSF_RX_DATA_READY_MASK) != 32'h0) r.rx_data_ready = 1'b0;
      if ((c & `ARSF_RX_FINAL_SLOT_MASK) != 32'h0) r.rx_final_slot = 1'b0;
      if ((c & `ARSF_RX_CLOCK_FAIL_MASK) != 32'h0) r.rx_clock_failure = 1'b0;
      if ((c & `ARSF_RX_UNEXP_SYNC_MASK) != 32'h0) r.rx_unexpected_sync = 1'b0;
      if ((c & `ARSF_TX_UNDERRUN_MASK) != 32'h0) r.tx_underrun = 1'b0;
      return r;
   endfunction : clear_flags

   function automatic logic [31:0] status_word(arsf_flags_s f);
      logic [31:0] w;
      w = 32'h0;
      if (f.rx_error_summary) w = w | `ARSF_RX_ERROR_SUMMARY_MASK;
      if (f.rx_overread_error) w = w | `ARSF_RX_OVERREAD_MASK;
      if (f.rx_frame_start) w = w | `ARSF_RX_FRAME_START_MASK;
      if (f.rx_data_ready) w = w | `ARSF_RX_DATA_READY_MASK;
      if (f.rx_final_slot) w = w | `ARSF_RX_FINAL_SLOT_MASK;
      if (f.rx_clock_failure) w = w | `ARSF_RX_CLOCK_FAIL_MASK;
      if (f.rx_unexpected_sync) w = w | `ARSF_RX_UNEXP_SYNC_MASK;
      if (f.tx_underrun) w = w | `ARSF_TX_UNDERRUN_MASK;
      return w;
   endfunction : status_word

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [`ARSF_SER_W:0] base;
      base    = '0;
      next_st = st;
      // Clear first, then set, so a same-cycle event survives the clear
      next_st.flags   = clear_flags(st.flags, clr);
      next_st.dma_req = link.word_valid;
      next_st.rdata   = 32'h0;

      // Frame sync, taken before a word of the same cycle
      if (link.frame_sync) begin
         next_st.flags.rx_frame_start = 1'b1;
         if (st.synced && !st.frame_done) begin
            next_st.flags.rx_unexpected_sync = 1'b1;
         end
         next_st.slot_idx   = '0;
         next_st.synced     = 1'b1;
         next_st.frame_done = 1'b0;
      end

      // Received word moved into the buffer
      if (link.word_valid) begin
         next_st.rx_buf              = link.word;
         next_st.flags.rx_data_ready = 1'b1;
         if (next_st.slot_idx == st.last_slot) begin
            next_st.flags.rx_final_slot = 1'b1;
            next_st.slot_idx            = '0;
            next_st.frame_done          = 1'b1;
         end else begin
            next_st.slot_idx = next_st.slot_idx + 1'b1;
         end
      end

      // Data port reads counted per slot; a new word opens a new slot
      base = link.word_valid ? '0 : st.read_cnt;
      if (rd_rx) begin
         if (base >= {1'b0, st.ser_cnt}) begin
            next_st.flags.rx_overread_error = 1'b1;
         end
         if (base != {(`ARSF_SER_W+1){1'b1}}) begin
            base = base + 1'b1;
         end
      end
      next_st.read_cnt = base;

      // Transmit buffer refill and serializer load
      if (link.tx_load) begin
         if (!st.tx_full && !wr_tx) begin
            next_st.flags.tx_underrun = 1'b1;
         end
         next_st.tx_full = 1'b0;
      end
      if (wr_tx) begin
         next_st.tx_buf  = bus.wdata;
         next_st.tx_full = 1'b1;
      end

      if (clk_fail) begin
         next_st.flags.rx_clock_failure = 1'b1;
      end

      // Summary derived from the new flags so it never lags them
      next_st.flags.rx_error_summary = next_st.flags.rx_unexpected_sync
                                     | next_st.flags.rx_clock_failure
                                     | next_st.flags.rx_overread_error;

      if (wr_ctrl) begin
         next_st.last_slot = bus.wdata[`ARSF_CTRL_LAST_LSB +: `ARSF_SLOT_W];
         next_st.ser_cnt   = bus.wdata[`ARSF_CTRL_SER_LSB +: `ARSF_SER_W];
         next_st.mon_en    = bus.wdata[`ARSF_CTRL_MON_BIT];
      end

      if (bus.rd) begin
         unique case (bus.addr)
            `ARSF_OFS_STATUS: next_st.rdata = status_word(st.flags);
            `ARSF_OFS_CTRL: begin
               next_st.rdata[`ARSF_CTRL_LAST_LSB +: `ARSF_SLOT_W] = st.last_slot;
               next_st.rdata[`ARSF_CTRL_SER_LSB +: `ARSF_SER_W]   = st.ser_cnt;
               next_st.rdata[`ARSF_CTRL_MON_BIT]                  = st.mon_en;
            end
            `ARSF_OFS_RXBUF: next_st.rdata = st.rx_buf;
            `ARSF_OFS_TXBUF: next_st.rdata = st.tx_buf;
            default: next_st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st           <= '0;
         st.last_slot <= `ARSF_CTRL_LAST_RESET;
         st.ser_cnt   <= `ARSF_CTRL_SER_RESET;
         st.mon_en    <= `ARSF_CTRL_MON_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_err_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_error_summary == (flags.rx_unexpected_sync | flags.rx_clock_failure
                                 | flags.rx_overread_error))
      else $error("error summary disagrees with its sources");

   chk_overread_set: assert property (@(posedge clk) disable iff (!rst_n)
      rd_rx && !link.word_valid && st.read_cnt >= {1'b0, st.ser_cnt}
      |=> flags.rx_overread_error)
      else $error("overread not flagged");

   chk_no_false_overread: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_overread_error && !(rd_rx && st.read_cnt >= {1'b0, st.ser_cnt})
      |=> !flags.rx_overread_error)
      else $error("overread flagged without cause");

   chk_frame_start_set: assert property (@(posedge clk) disable iff (!rst_n)
      link.frame_sync |=> flags.rx_frame_start)
      else $error("frame start not flagged");

   chk_data_ready_dma: assert property (@(posedge clk) disable iff (!rst_n)
      link.word_valid |=> flags.rx_data_ready && rx_dma_req)
      else $error("data ready or dma request missing");

   chk_dma_pulse_cause: assert property (@(posedge clk) disable iff (!rst_n)
      rx_dma_req |-> $past(link.word_valid) && flags.rx_data_ready)
      else $error("dma request without received word");

   chk_final_slot_set: assert property (@(posedge clk) disable iff (!rst_n)
      link.word_valid && !link.frame_sync && st.slot_idx == st.last_slot
      |=> flags.rx_final_slot && flags.rx_data_ready && st.slot_idx == '0)
      else $error("final slot not flagged");

   chk_unexp_sync_set: assert property (@(posedge clk) disable iff (!rst_n)
      link.frame_sync && st.synced && !st.frame_done |=> flags.rx_unexpected_sync)
      else $error("unexpected sync not flagged");

   chk_tx_underrun_set: assert property (@(posedge clk) disable iff (!rst_n)
      link.tx_load && !st.tx_full && !wr_tx |=> flags.tx_underrun)
      else $error("transmit underrun not flagged");

   chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_frame_start && (clr & `ARSF_RX_FRAME_START_MASK) == 32'h0
      |=> flags.rx_frame_start)
      else $error("frame start flag dropped without clear");

   chk_clkfail_latch: assert property (@(posedge clk) disable iff (!rst_n)
      clk_fail |=> flags.rx_clock_failure && flags.rx_error_summary)
      else $error("clock failure not latched");

   // Sticky flags may only fall through a software write of their mask
   chk_overread_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_overread_error && (clr & `ARSF_RX_OVERREAD_MASK) == 32'h0
      |=> flags.rx_overread_error)
      else $error("overread flag dropped without clear");

   chk_ready_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_data_ready && (clr & `ARSF_RX_DATA_READY_MASK) == 32'h0
      |=> flags.rx_data_ready)
      else $error("data ready flag dropped without clear");

   chk_underrun_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.tx_underrun && (clr & `ARSF_TX_UNDERRUN_MASK) == 32'h0
      |=> flags.tx_underrun)
      else $error("underrun flag dropped without clear");

   chk_sync_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_unexpected_sync && (clr & `ARSF_RX_UNEXP_SYNC_MASK) == 32'h0
      |=> flags.rx_unexpected_sync)
      else $error("unexpected sync flag dropped without clear");

   chk_clkfail_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      flags.rx_clock_failure && (clr & `ARSF_RX_CLOCK_FAIL_MASK) == 32'h0
      |=> flags.rx_clock_failure)
      else $error("clock failure flag dropped without clear");

   chk_ready_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (clr & `ARSF_RX_DATA_READY_MASK) != 32'h0 && !link.word_valid
      |=> !flags.rx_data_ready)
      else $error("data ready flag not cleared");

   chk_start_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (clr & `ARSF_RX_FRAME_START_MASK) != 32'h0 && !link.frame_sync
      |=> !flags.rx_frame_start)
      else $error("frame start flag not cleared");

   // A flag that rises needs its own cause in the cycle before
   chk_no_false_start: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_frame_start && !link.frame_sync |=> !flags.rx_frame_start)
      else $error("frame start flagged without sync");

   chk_no_false_ready: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_data_ready && !link.word_valid |=> !flags.rx_data_ready)
      else $error("data ready flagged without word");

   chk_dma_single: assert property (@(posedge clk) disable iff (!rst_n)
      !link.word_valid |=> !rx_dma_req)
      else $error("dma request longer than one cycle");

   chk_no_false_final: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_final_slot && !link.word_valid |=> !flags.rx_final_slot)
      else $error("final slot flagged without word");

   chk_final_with_ready: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(flags.rx_final_slot) |-> flags.rx_data_ready)
      else $error("final slot flagged without data ready");

   chk_no_false_sync: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_unexpected_sync && !(link.frame_sync && st.synced && !st.frame_done)
      |=> !flags.rx_unexpected_sync)
      else $error("unexpected sync flagged without cause");

   chk_no_false_underrun: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.tx_underrun && !(link.tx_load && !st.tx_full && !wr_tx)
      |=> !flags.tx_underrun)
      else $error("underrun flagged without cause");

   chk_no_false_clkfail: assert property (@(posedge clk) disable iff (!rst_n)
      !flags.rx_clock_failure && !clk_fail |=> !flags.rx_clock_failure)
      else $error("clock failure flagged without cause");

endmodule : arsf_status

// File: tb/arsf_link_model.sv
`timescale 1ns/100ps
// Far end of the serial link: frames words in, pulls words from the tx buffer
module arsf_link_model (
   input  wire logic            clk,
   output arsf_pkg::arsf_link_s link,
   output logic                 bclk
);
   import arsf_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      link = '0;
      bclk = 1'b0;
   end
   // One slot is four cycles; bit clock stands low between slots
   task automatic slot(input logic sync, input logic [31:0] w);
      @(posedge clk);
      link.frame_sync <= sync;
      link.word_valid <= 1'b1;
      link.word       <= w;
      bclk            <= 1'b1;
      @(posedge clk);
      link.frame_sync <= 1'b0;
      link.word_valid <= 1'b0;
      link.word       <= ~w; // Stale word must not look valid
      @(posedge clk);
      bclk <= 1'b0;
      @(posedge clk);
   endtask : slot
   task automatic load_tx();
      @(posedge clk);
      link.tx_load <= 1'b1;
      @(posedge clk);
      link.tx_load <= 1'b0;
   endtask : load_tx
   // Bit clock toggling every cycle, a period shorter than the monitor allows
   task automatic fast_bclk(input int n);
      repeat (n) begin
         @(posedge clk);
         bclk <= 1'b1;
         @(posedge clk);
         bclk <= 1'b0;
      end
   endtask : fast_bclk
endmodule : arsf_link_model

// File: tb/tb.sv
`timescale 1ns/100ps
`include "arsf_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import arsf_pkg::*;
   localparam logic [31:0] ALL = 32'hffffffff;
   localparam logic [31:0] FRM = 32'h00700000;
   logic        clk, rst_n, rx_dma_req, bclk;
   arsf_bus_s   bus;
   arsf_link_s  link;
   arsf_flags_s flags;
   logic [31:0] rdata, tx_word, exp, rv, w;
   logic [4:0]  last;
   int          failures, n_checks, n_dma, n_words, seed;
   arsf_status #(.MIN_CYC(3), .MAX_CYC(8)) arsf_status_inst (
      .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .link(link),
      .rx_bit_clk(bclk), .tx_word(tx_word), .rx_dma_req(rx_dma_req), .flags(flags));
   arsf_link_model arsf_link_model_inst (.clk(clk), .link(link), .bclk(bclk));
   ////////////////////////////////////////////////////////////////////////////////
   // Summary folds in overread, clock failure and unexpected sync
   function automatic logic [31:0] summ(input logic [31:0] s);
      summ = s | ((|(s & 32'h00860000)) ? `ARSF_RX_ERROR_SUMMARY_MASK : 32'h0);
   endfunction : summ
   function automatic arsf_flags_s to_flags(input logic [31:0] s);
      to_flags = {s[24], s[23], s[22], s[21], s[20], s[18], s[17], s[0]};
   endfunction : to_flags
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= d;
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic chk_st();
      rd(`ARSF_OFS_STATUS, rv);
      `CHK(rv, summ(exp))
      `CHK(flags, to_flags(summ(exp)))
   endtask : chk_st
   task automatic clr(input logic [31:0] m);
      wr(`ARSF_OFS_STATUS, m);
      exp &= ~m;
   endtask : clr
   task automatic send(input logic sync, input logic [31:0] d);
      arsf_link_model_inst.slot(sync, d);
      n_words++;
   endtask : send
   task automatic report_and_stop();
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rx_dma_req === 1'b1) n_dma++;
   end
   // Whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   initial begin
      seed = 49929;
      rst_n = 1'b0;
      bus = '0;
      exp = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      `CHK(flags, to_flags(32'h0))
      rd(`ARSF_OFS_CTRL, rv);
      `CHK(rv, 32'h00000101)
      // Read data stands for one cycle only
      @(posedge clk);
      #1;
      `CHK(rdata, 32'h0)
      rd(8'h10, rv);
      `CHK(rv, 32'h0)
      w = $random(seed);
      send(1'b1, w);
      exp = `ARSF_RX_FRAME_START_MASK | `ARSF_RX_DATA_READY_MASK;
      chk_st();
      clr(ALL);
      chk_st();
      w = $random(seed);
      send(1'b0, w);
      exp = `ARSF_RX_DATA_READY_MASK | `ARSF_RX_FINAL_SLOT_MASK;
      chk_st();
      rd(`ARSF_OFS_RXBUF, rv);
      `CHK(rv, w)
      clr(ALL);
      // Random frame lengths, sync always rides on slot 0
      for (int i = 0; i < 6; i++) begin
         last = 5'($random(seed) & 3);
         wr(`ARSF_OFS_CTRL, {27'h0, last} | 32'h00000100);
         for (int s = 0; s <= int'(last); s++) send(s == 0, $random(seed));
         exp = FRM;
         chk_st();
         clr(ALL);
      end
      wr(`ARSF_OFS_CTRL, 32'h00000103);
      send(1'b1, $random(seed));
      send(1'b0, $random(seed));
      send(1'b1, $random(seed));
      repeat (3) send(1'b0, $random(seed));
      exp = FRM | `ARSF_RX_UNEXP_SYNC_MASK;
      chk_st();
      clr(`ARSF_RX_UNEXP_SYNC_MASK);
      chk_st();
      clr(ALL);
      // Two receivers: the third read in one slot is one too many
      wr(`ARSF_OFS_CTRL, 32'h00000200);
      w = $random(seed);
      send(1'b1, w);
      repeat (2) rd(`ARSF_OFS_RXBUF, rv);
      exp = FRM;
      chk_st();
      rd(`ARSF_OFS_RXBUF, rv);
      `CHK(rv, w)
      exp |= `ARSF_RX_OVERREAD_MASK;
      chk_st();
      clr(ALL);
      w = $random(seed);
      wr(`ARSF_OFS_TXBUF, w);
      `CHK(tx_word, w)
      rd(`ARSF_OFS_TXBUF, rv);
      `CHK(rv, w)
      arsf_link_model_inst.load_tx();
      chk_st();
      arsf_link_model_inst.load_tx();
      exp = `ARSF_TX_UNDERRUN_MASK;
      chk_st();
      clr(ALL);
      // Monitor on; bit clock then stops dead after one slot
      wr(`ARSF_OFS_CTRL, 32'h00010100);
      send(1'b1, $random(seed));
      repeat (20) @(posedge clk);
      exp = FRM | `ARSF_RX_CLOCK_FAIL_MASK;
      chk_st();
      wr(`ARSF_OFS_STATUS, `ARSF_RX_ERROR_SUMMARY_MASK);
      chk_st();
      rd(`ARSF_OFS_CTRL, rv);
      `CHK(rv, 32'h00010100)
      // Clock back but far too fast: a short period is a failure as well
      clr(`ARSF_RX_CLOCK_FAIL_MASK);
      chk_st();
      arsf_link_model_inst.fast_bclk(3);
      exp |= `ARSF_RX_CLOCK_FAIL_MASK;
      chk_st();
      `CHK(n_dma, n_words)
      // Reset in mid-run returns flags, control and transmit buffer to idle
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      `CHK(flags, to_flags(32'h0))
      `CHK(tx_word, 32'h0)
      rd(`ARSF_OFS_CTRL, rv);
      `CHK(rv, 32'h00000101)
      report_and_stop();
   end
endmodule : tb
